// [rtl/nonmaskable_interrupt_control.sv]
// Non-maskable arbitration, interrupt entry, return and maskable vector map.
`timescale 1ns/1ps
`default_nettype none
module nonmaskable_interrupt_control
  import nmi_ctrl_pkg::*;
(
  // Clock and reset.
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  // Register port.
  input  wire logic [7:0]              reg_addr,
  input  wire logic [31:0]             reg_wdata,
  input  wire logic                    reg_write,
  input  wire logic                    reg_read,
  output var  logic [31:0]             reg_rdata,
  // Request sources.
  input  wire logic                    nmi_pin,
  input  wire logic                    watchdog_overflow,
  input  wire logic [MASK_SOURCES-1:0] maskable_request,
  // Processor side.
  input  wire cpu_context_s            cpu_context,
  input  wire logic                    return_from_interrupt_instr,
  input  wire logic                    status_write,
  input  wire logic [31:0]             status_wdata,
  output var  entry_s                  entry,
  output var  logic [4:0]              maskable_ack_index,
  output var  logic                    abort_instruction,
  output var  logic                    pc_load,
  output var  logic [31:0]             pc_target,
  output var  logic [31:0]             program_status_word,
  output var  logic [31:0]             exception_cause_register,
  output var  logic [31:0]             nonmaskable_saved_pc,
  output var  logic [31:0]             nonmaskable_saved_status,
  output var  logic [31:0]             maskable_saved_pc,
  output var  logic [31:0]             maskable_saved_status
);

  typedef struct packed {
    logic [1:0]  edge_mode;
    logic [1:0]  watchdog_mode_register;
    logic        pin_prev;
    logic        pin_pending;
    logic        wdt_pending;
    serve_e      serving;
    logic [31:0] rdata;
    entry_s      entry;
    logic [4:0]  ack_index;
    logic        abort;
    logic        pc_load;
    logic [31:0] pc_target;
    logic [31:0] sw;
    logic [31:0] cause_reg;
    logic [31:0] nm_pc;
    logic [31:0] nm_sw;
    logic [31:0] mk_pc;
    logic [31:0] mk_sw;
  } state_s;

  state_s s;
  state_s next_s;

  logic        pin_edge;
  logic        wdt_request;
  logic        any_mask;
  logic [4:0]  mask_index;
  logic [15:0] mask_code;
  logic [31:0] return_address;
  logic        take_wdt;
  logic        take_pin;
  logic        take_illegal;
  logic        take_mask;

  // Lowest index is the lowest default priority number and therefore ranks highest.
  function automatic logic [4:0] lowest_set(input logic [MASK_SOURCES-1:0] req);
    logic [4:0] idx;
    idx = 5'd0;
    for (int i = MASK_SOURCES - 1; i >= 0; i--) begin
      if (req[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction

  always_comb begin
    next_s         = s;
    next_s.entry   = '0;
    next_s.abort   = 1'b0;
    next_s.pc_load = 1'b0;
    next_s.pin_prev = nmi_pin;

    unique case (edge_mode_e'(s.edge_mode))
      EDGE_NONE:    pin_edge = 1'b0;
      EDGE_RISING:  pin_edge = nmi_pin & ~s.pin_prev;
      EDGE_FALLING: pin_edge = ~nmi_pin & s.pin_prev;
      EDGE_BOTH:    pin_edge = nmi_pin ^ s.pin_prev;
    endcase
    // Only the pin edge and the gated watchdog can ever reach the two latches.
    wdt_request = watchdog_overflow && (s.watchdog_mode_register == WDT_NMI_MODE);

    any_mask   = |maskable_request;
    mask_index = lowest_set(maskable_request);
    if (mask_index < MASK_HI_FIRST) begin
      mask_code = MASK_CODE_LO + 16'({mask_index, 4'h0});
    end else begin
      mask_code = MASK_CODE_HI + 16'({mask_index - MASK_HI_FIRST, 4'h0});
    end

    if (cpu_context.illegal_opcode) begin
      return_address = cpu_context.current_address + ILLEGAL_STEP;
    end else if (cpu_context.abortable) begin
      return_address = cpu_context.current_address;
    end else begin
      return_address = cpu_context.following_instruction_address;
    end

    // Non-maskable arbitration looks at the latches only, so a pin or watchdog request is seen the cycle after it arrives.
    take_wdt = 1'b0;
    take_pin = 1'b0;
    take_illegal = 1'b0;
    take_mask = 1'b0;
    if (!return_from_interrupt_instr) begin
      unique case (s.serving)
        SERVE_IDLE: begin
          take_wdt = s.wdt_pending;
          take_pin = s.pin_pending && !s.wdt_pending;
        end
        SERVE_PIN: begin
          take_wdt = s.wdt_pending && !s.sw[SW_INSERVICE_BIT];
        end
        SERVE_WDT: begin
          take_wdt = 1'b0;
        end
        default: begin
          take_wdt = 1'b0;
        end
      endcase
      take_illegal = !take_wdt && !take_pin && cpu_context.illegal_opcode;
      // Maskable work waits out both flags, so only an illegal-opcode entry can nest and overwrite its saves.
      take_mask = !take_wdt && !take_pin && !take_illegal && any_mask
                  && !s.sw[SW_DISABLE_BIT] && !s.sw[SW_INSERVICE_BIT];
    end

    // New arrivals set the latches after acceptance clears them, so set wins.
    if (take_pin) begin
      next_s.pin_pending = 1'b0;
    end
    if (take_wdt) begin
      next_s.wdt_pending = 1'b0;
      if (s.serving == SERVE_IDLE) begin
        next_s.pin_pending = 1'b0;
      end
    end
    if (pin_edge && !(wdt_request && s.serving == SERVE_IDLE)) begin
      next_s.pin_pending = 1'b1;
    end
    if (wdt_request) begin
      next_s.wdt_pending = 1'b1;
    end

    // A software write of the status word loses the flag bits that an entry in the same cycle writes, and all of it to a same-cycle return.
    if (status_write) begin
      next_s.sw = status_wdata;
    end

    if (take_wdt || take_pin) begin
      next_s.nm_pc = return_address;
      next_s.nm_sw = s.sw;
      next_s.sw[SW_INSERVICE_BIT] = 1'b1;
      next_s.sw[SW_DISABLE_BIT]   = 1'b1;
      next_s.sw[SW_EXCEPT_BIT]    = 1'b0;
      next_s.entry.strobe = 1'b1;
      next_s.pc_load = 1'b1;
      next_s.abort = cpu_context.abortable;
      if (take_wdt) begin
        next_s.serving      = SERVE_WDT;
        next_s.entry.cause  = WDT_CAUSE;
        next_s.entry.vector = WDT_VECTOR;
        next_s.pc_target    = WDT_VECTOR;
      end else begin
        next_s.serving      = SERVE_PIN;
        next_s.cause_reg[31:16] = PIN_CAUSE;
        next_s.entry.cause  = PIN_CAUSE;
        next_s.entry.vector = PIN_VECTOR;
        next_s.pc_target    = PIN_VECTOR;
      end
    end else if (take_illegal || take_mask) begin
      next_s.mk_pc = return_address;
      next_s.mk_sw = s.sw;
      next_s.sw[SW_DISABLE_BIT] = 1'b1;
      next_s.sw[SW_EXCEPT_BIT]  = 1'b0;
      // An illegal opcode has already run to its end, so its entry never aborts.
      next_s.entry.strobe = 1'b1;
      next_s.pc_load = 1'b1;
      next_s.abort = cpu_context.abortable && !cpu_context.illegal_opcode;
      if (take_illegal) begin
        next_s.cause_reg[15:0] = ILLEGAL_CAUSE;
        next_s.entry.cause  = ILLEGAL_CAUSE;
        next_s.entry.vector = ILLEGAL_VECTOR;
        next_s.pc_target    = ILLEGAL_VECTOR;
      end else begin
        next_s.ack_index    = mask_index;
        next_s.cause_reg[15:0] = mask_code;
        next_s.entry.cause  = mask_code;
        next_s.entry.vector = {16'h0000, mask_code};
        next_s.pc_target    = {16'h0000, mask_code};
      end
    end else if (return_from_interrupt_instr && !s.sw[SW_EXCEPT_BIT]) begin
      // The in-service flag alone picks which pair of saves the return uses.
      if (s.sw[SW_INSERVICE_BIT]) begin
        // Watchdog servicing has no way back; the system must be reset.
        if (s.serving != SERVE_WDT) begin
          next_s.pc_load   = 1'b1;
          next_s.pc_target = s.nm_pc;
          next_s.sw        = s.nm_sw;
          next_s.serving   = SERVE_IDLE;
        end
      end else begin
        next_s.pc_load   = 1'b1;
        next_s.pc_target = s.mk_pc;
        next_s.sw        = s.mk_sw;
        if (s.serving == SERVE_PIN) begin
          next_s.serving = SERVE_IDLE;
        end
      end
    end

    next_s.rdata = '0;
    if (reg_write && reg_addr == CTRL_OFFSET) begin
      next_s.edge_mode = reg_wdata[CTRL_EDGE_LSB +: 2];
      next_s.watchdog_mode_register = {reg_wdata[CTRL_WDT_HI_BIT], reg_wdata[CTRL_WDT_LO_BIT]};
    end
    if (reg_read) begin
      if (reg_addr == CTRL_OFFSET) begin
        next_s.rdata[CTRL_EDGE_LSB +: 2]  = s.edge_mode;
        next_s.rdata[CTRL_WDT_HI_BIT]     = s.watchdog_mode_register[1];
        next_s.rdata[CTRL_WDT_LO_BIT]     = s.watchdog_mode_register[0];
      end else if (reg_addr == STATUS_OFFSET) begin
        next_s.rdata[3:0] = {s.pin_pending, s.wdt_pending, s.serving};
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s       <= '0;
      // Interrupts come up disabled so nothing maskable is taken before setup.
      s.sw    <= STATUS_WORD_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata                = s.rdata;
  assign entry                    = s.entry;
  assign maskable_ack_index       = s.ack_index;
  assign abort_instruction        = s.abort;
  assign pc_load                  = s.pc_load;
  assign pc_target                = s.pc_target;
  assign program_status_word      = s.sw;
  assign exception_cause_register = s.cause_reg;
  assign nonmaskable_saved_pc     = s.nm_pc;
  assign nonmaskable_saved_status = s.nm_sw;
  assign maskable_saved_pc        = s.mk_pc;
  assign maskable_saved_status    = s.mk_sw;

  // Checks watch the registered outputs one cycle after the decision.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence pin_entry_seq;
    entry.strobe && entry.cause == PIN_CAUSE;
  endsequence

  sequence wdt_entry_seq;
    entry.strobe && entry.cause == WDT_CAUSE;
  endsequence

  AST_WDT_GATED: assert property (wdt_entry_seq |-> $past(s.watchdog_mode_register, 2) == WDT_NMI_MODE
                                  || $past(s.watchdog_mode_register, 3) == WDT_NMI_MODE)
    else $error("watchdog entry without enabling mode");

  AST_NMI_VECTORS: assert property (entry.strobe && entry.cause == PIN_CAUSE |->
                                    entry.vector == PIN_VECTOR && pc_target == PIN_VECTOR && pc_load)
    else $error("pin entry vector wrong");

  AST_NMI_FLAGS: assert property ((pin_entry_seq or wdt_entry_seq) |->
                                  program_status_word[SW_INSERVICE_BIT]
                                  && program_status_word[SW_DISABLE_BIT]
                                  && !program_status_word[SW_EXCEPT_BIT])
    else $error("status flags wrong after non-maskable entry");

  AST_PIN_CAUSE: assert property (pin_entry_seq |-> exception_cause_register[31:16] == PIN_CAUSE
                                  && exception_cause_register[15:0] == $past(s.cause_reg[15:0]))
    else $error("cause register wrong after pin entry");

  AST_SAVE_STATUS: assert property (pin_entry_seq or wdt_entry_seq |->
                                    nonmaskable_saved_status == $past(s.sw))
    else $error("status word not saved on entry");

  AST_WDT_OVER_PIN: assert property (s.serving == SERVE_IDLE && s.pin_pending && s.wdt_pending
                                     && !return_from_interrupt_instr |=> wdt_entry_seq ##0 !s.pin_pending)
    else $error("pin not discarded when watchdog wins");

  AST_PIN_WAITS: assert property (s.serving == SERVE_PIN |=>
                                  !(entry.strobe && entry.cause == PIN_CAUSE))
    else $error("pin entry during pin servicing");

  AST_WDT_HELD: assert property (s.serving == SERVE_PIN && s.sw[SW_INSERVICE_BIT] |=>
                                 !(entry.strobe && entry.cause == WDT_CAUSE))
    else $error("watchdog preempted while in-service set");

  AST_WDT_PREEMPT: assert property (s.serving == SERVE_PIN && !s.sw[SW_INSERVICE_BIT] && s.wdt_pending
                                    && !return_from_interrupt_instr |=> wdt_entry_seq)
    else $error("watchdog did not preempt");

  AST_NO_WDT_RETURN: assert property (s.serving == SERVE_WDT && return_from_interrupt_instr |=>
                                      !pc_load && s.serving == SERVE_WDT)
    else $error("return taken from watchdog servicing");

  AST_PIN_RETURN: assert property (s.serving == SERVE_PIN && return_from_interrupt_instr
                                   && !s.sw[SW_EXCEPT_BIT] && s.sw[SW_INSERVICE_BIT] |=>
                                   pc_load && pc_target == $past(s.nm_pc)
                                   && program_status_word == $past(s.nm_sw))
    else $error("return did not restore saved state");

  AST_STROBE_ONE: assert property (entry.strobe |=> !entry.strobe || $past(s.serving) != s.serving
                                   || entry.cause != $past(entry.cause))
    else $error("accept strobe repeated for one request");

  AST_NMI_BEATS_MASK: assert property (s.wdt_pending && s.serving == SERVE_IDLE
                                       && !return_from_interrupt_instr && any_mask |=>
                                       wdt_entry_seq)
    else $error("maskable request beat a non-maskable one");

  sequence mask_entry_seq;
    entry.strobe && entry.cause >= MASK_CODE_LO;
  endsequence

  sequence illegal_entry_seq;
    entry.strobe && entry.cause == ILLEGAL_CAUSE;
  endsequence

  AST_WDT_VECTOR: assert property (wdt_entry_seq |->
                                   entry.vector == WDT_VECTOR && pc_target == WDT_VECTOR && pc_load)
    else $error("watchdog entry vector wrong");

  // Maskable codes run on in steps of 0x10 across both halves of the map.
  AST_MASK_CODE: assert property (mask_entry_seq |-> entry.cause == MASK_CODE_LO + 16'({maskable_ack_index, 4'h0})
                                  && entry.vector == {16'h0000, entry.cause})
    else $error("maskable cause or vector wrong");

  AST_LOWEST_WINS: assert property (mask_entry_seq |-> !(|($past(maskable_request)
                                    & ((MASK_SOURCES'(1) << maskable_ack_index) - MASK_SOURCES'(1)))))
    else $error("maskable request of lower number was passed over");

  AST_ILLEGAL_RETURN: assert property (illegal_entry_seq |->
                                       maskable_saved_pc == $past(cpu_context.current_address) + ILLEGAL_STEP)
    else $error("illegal opcode return address wrong");

  AST_MASK_ABORT: assert property (mask_entry_seq |-> abort_instruction == $past(cpu_context.abortable))
    else $error("abort flag wrong on maskable entry");

  AST_FOLLOWING_SAVED: assert property ((pin_entry_seq ##0 (!$past(cpu_context.abortable) && !$past(cpu_context.illegal_opcode)))
                                       |-> nonmaskable_saved_pc == $past(cpu_context.following_instruction_address))
    else $error("following address not saved on pin entry");

  AST_PIN_UNMASKED: assert property (s.pin_pending && s.serving == SERVE_IDLE
                                     && !return_from_interrupt_instr |=> entry.strobe)
    else $error("pending pin request not accepted");

endmodule
`default_nettype wire

// [rtl/nmi_ctrl_pkg.sv]
// Constants, layouts and types for the non-maskable interrupt control block.
// Notes on behaviour
// - Maskable priorities 11 to 25 get codes 0x0130..0x0210; vector is the code.
// - Maskable priorities 26 to 37 get codes 0x0220..0x02D0; vector is the code.
// - Among simultaneous maskable requests the lowest priority number wins.
// - Interrupt on a non-abortable, legal instruction saves the following instruction address.
// - Abortable instruction interrupted: save its own address so it restarts.
// - Illegal opcode saves faulting address plus 4.
// - Non-maskable requests are accepted even with interrupts disabled.
// - Non-maskable requests win over every maskable request.
// - Exactly two non-maskable sources: the pin and the watchdog.
// - Pin edge detection is rising, falling, both or none.
// - Pin and watchdog together: watchdog serviced, pin request discarded.
// - New pin request during pin servicing waits until the return.
// - Watchdog request during pin servicing waits while in-service flag is 1.
// - In-service flag cleared during pin servicing: watchdog preempts at once.
// - Return resumes only from pin servicing, never from watchdog servicing.
// - Non-maskable entry saves return address and status word.
// - Pin entry writes 0x0010 into cause upper half, lower half kept.
// - Non-maskable entry sets in-service and disable flags, clears exception flag.
// - Non-maskable entry vectors to 0x00000010 (pin) or 0x00000020 (watchdog).
// - Return with exception flag 0, in-service 1 restores from non-maskable saves.
package nmi_ctrl_pkg;

  localparam logic [7:0]  CTRL_OFFSET      = 8'h00;
  localparam logic [7:0]  STATUS_OFFSET    = 8'h04;
  localparam int          CTRL_EDGE_LSB    = 0;
  localparam int          CTRL_WDT_LO_BIT  = 3;
  localparam int          CTRL_WDT_HI_BIT  = 4;
  localparam int          SW_INSERVICE_BIT = 7;
  localparam int          SW_EXCEPT_BIT    = 6;
  localparam int          SW_DISABLE_BIT   = 5;
  localparam logic [31:0] STATUS_WORD_RESET = 32'h0000_0020;
  localparam logic [1:0]  WDT_NMI_MODE     = 2'b10;
  localparam logic [15:0] PIN_CAUSE        = 16'h0010;
  localparam logic [15:0] WDT_CAUSE        = 16'h0020;
  localparam logic [15:0] ILLEGAL_CAUSE    = 16'h0060;
  localparam logic [31:0] PIN_VECTOR       = 32'h0000_0010;
  localparam logic [31:0] WDT_VECTOR       = 32'h0000_0020;
  localparam logic [31:0] ILLEGAL_VECTOR   = 32'h0000_0060;
  localparam logic [15:0] MASK_CODE_LO     = 16'h0130;
  localparam logic [15:0] MASK_CODE_HI     = 16'h0220;
  localparam logic [4:0]  MASK_HI_FIRST    = 5'd15;
  localparam int          MASK_SOURCES     = 27;
  localparam logic [31:0] ILLEGAL_STEP     = 32'h0000_0004;

  typedef enum logic [1:0] {
    EDGE_NONE    = 2'b00,
    EDGE_RISING  = 2'b01,
    EDGE_FALLING = 2'b10,
    EDGE_BOTH    = 2'b11
  } edge_mode_e;

  typedef enum logic [1:0] {
    SERVE_IDLE = 2'b00,
    SERVE_PIN  = 2'b01,
    SERVE_WDT  = 2'b10
  } serve_e;

  typedef struct packed {
    logic [31:0] current_address;
    logic [31:0] following_instruction_address;
    logic        abortable;
    logic        illegal_opcode;
  } cpu_context_s;

  typedef struct packed {
    logic        strobe;
    logic [15:0] cause;
    logic [31:0] vector;
  } entry_s;

endpackage

// [verif/cpu_model.sv]
// Processor-side partner: follows entries, runs at the new PC, issues returns.
`timescale 1ns/1ps
`default_nettype none
module cpu_model
  import nmi_ctrl_pkg::*;
(
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         reset_n,
  // Bench controls.
  input  wire logic         ret_req,
  input  wire logic         rogue,
  input  wire logic         abort_in,
  input  wire logic         illegal_in,
  // Design side.
  input  wire entry_s       entry,
  input  wire logic         pc_load,
  input  wire logic [31:0]  pc_target,
  output var  cpu_context_s cpu_context,
  output var  logic         return_from_interrupt_instr
);
  logic in_wdt;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cpu_context <= '{32'h0000_1000, 32'h0000_1004, 1'b0, 1'b0};
      in_wdt <= 1'b0;
      return_from_interrupt_instr <= 1'b0;
    end else begin
      if (pc_load) begin
        cpu_context.current_address <= pc_target;
        cpu_context.following_instruction_address <= pc_target + 32'h0000_0004;
      end
      cpu_context.abortable <= abort_in;
      cpu_context.illegal_opcode <= illegal_in;
      if (entry.strobe) in_wdt <= (entry.cause == WDT_CAUSE);
      // Software resets after watchdog servicing; rogue lets a scenario break that.
      return_from_interrupt_instr <= ret_req && (!in_wdt || rogue);
    end
  end
endmodule
`default_nettype wire

// [verif/nonmaskable_interrupt_control_tb_top.sv]
// Self-checking bench for the non-maskable interrupt control block.
`timescale 1ns/1ps
`default_nettype none
module nonmaskable_interrupt_control_tb_top;
  import nmi_ctrl_pkg::*;
  logic                    clk, reset_n, reg_write, reg_read, nmi_pin, wdt_ovf;
  logic                    ret_req, rogue, abort_in, illegal_in, status_write, ret_i;
  logic                    abort_o, pc_load;
  logic [7:0]              reg_addr;
  logic [4:0]              ack_idx;
  logic [31:0]             reg_wdata, reg_rdata, status_wdata, pc_target, sw_o, cause_o;
  logic [31:0]             nm_pc, nm_sw, mk_pc, mk_sw, d, got, exp_ret, old_sw, old_cause;
  logic [MASK_SOURCES-1:0] mreq;
  cpu_context_s            ctx;
  entry_s                  entry;
  int                      fails, tests_run, lo;
  nonmaskable_interrupt_control u_dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .nmi_pin(nmi_pin), .watchdog_overflow(wdt_ovf), .maskable_request(mreq),
    .cpu_context(ctx), .return_from_interrupt_instr(ret_i), .status_write(status_write),
    .status_wdata(status_wdata), .entry(entry), .maskable_ack_index(ack_idx),
    .abort_instruction(abort_o), .pc_load(pc_load), .pc_target(pc_target),
    .program_status_word(sw_o), .exception_cause_register(cause_o), .nonmaskable_saved_pc(nm_pc),
    .nonmaskable_saved_status(nm_sw), .maskable_saved_pc(mk_pc), .maskable_saved_status(mk_sw));
  cpu_model u_cpu (.clk(clk), .reset_n(reset_n), .ret_req(ret_req), .rogue(rogue),
    .abort_in(abort_in), .illegal_in(illegal_in), .entry(entry), .pc_load(pc_load),
    .pc_target(pc_target), .cpu_context(ctx), .return_from_interrupt_instr(ret_i));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [31:0] b(input bit x);
    return {31'h0000_0000, x};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    tick(1);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_read <= 1'b1;
    tick(1);
    reg_read <= 1'b0;
    d = reg_rdata;
  endtask
  task automatic do_reset();
    reset_n <= 1'b0;
    tick(2);
    reset_n <= 1'b1;
    tick(1);
  endtask
  // Waits a bounded span for pc_load (load set) or the entry strobe; got is 1 when it came.
  task automatic wait_for(input bit load, input int n);
    got = 32'h0000_0000;
    repeat (n) begin
      tick(1);
      if ((load ? pc_load : entry.strobe) === 1'b1) begin
        got = 32'h0000_0001;
        break;
      end
    end
  endtask
  task automatic capture();
    old_sw = sw_o;
    old_cause = cause_o;
    exp_ret = ctx.abortable ? ctx.current_address : ctx.following_instruction_address;
  endtask
  task automatic chk_entry(input logic [15:0] c, input logic [31:0] saved);
    chk("cause", b(1'b0) | c, b(1'b0) | entry.cause);
    chk("vector", b(1'b0) | c, entry.vector);
    chk("pc target", b(1'b0) | c, pc_target);
    chk("saved pc", exp_ret, saved);
    chk("abort", b(ctx.abortable), b(abort_o));
  endtask
  task automatic chk_pin();
    chk_entry(PIN_CAUSE, nm_pc);
    chk("saved status", old_sw, nm_sw);
    chk("cause reg", {PIN_CAUSE, old_cause[15:0]}, cause_o);
    chk("status flags", 32'h0000_00A0, sw_o & 32'h0000_00E0);
  endtask
  task automatic do_return();
    ret_req <= 1'b1;
    tick(1);
    ret_req <= 1'b0;
    wait_for(1'b1, 4);
    chk("return", 32'h0000_0001, got);
    chk("restored pc", nm_pc, pc_target);
    chk("restored status", nm_sw, sw_o);
  endtask
  initial begin
    #100000;
    fails++;
    tally_and_finish();
  end
  initial begin
    {reset_n, reg_write, reg_read, nmi_pin, wdt_ovf, ret_req, rogue} = '0;
    {abort_in, illegal_in, status_write, reg_addr, reg_wdata, status_wdata, mreq} = '0;
    void'($urandom(74));
    do_reset();
    chk("status reset", STATUS_WORD_RESET, sw_o);
    rd(8'h04);
    chk("status", 32'h0000_0000, d);
    rd(8'h10);
    chk("unmapped", 32'h0000_0000, d);
    $display("test reset done");
    for (int m = 0; m < 4; m++) begin
      wr(8'h00, m);
      for (int k = 0; k < 2; k++) begin
        abort_in <= 1'($urandom_range(1, 0));
        tick(2);
        capture();
        nmi_pin <= (k == 0);
        wait_for(1'b0, 4);
        chk("edge", b(m == 3 || (m == 1 && k == 0) || (m == 2 && k == 1)), got);
        if (got[0]) begin
          chk_pin();
          do_return();
        end
      end
    end
    $display("test edges done");
    for (int m = 0; m < 4; m++) begin
      wr(8'h00, m << 3);
      capture();
      wdt_ovf <= 1'b1;
      tick(1);
      wdt_ovf <= 1'b0;
      wait_for(1'b0, 4);
      chk("wdt mode", b(m == 2), got);
      if (got[0]) begin
        chk_entry(WDT_CAUSE, nm_pc);
        rogue <= 1'b1;
        ret_req <= 1'b1;
        tick(1);
        ret_req <= 1'b0;
        wait_for(1'b1, 4);
        chk("wdt return", 32'h0000_0000, got);
        rogue <= 1'b0;
        do_reset();
      end
    end
    wr(8'h00, 32'h0000_0011);
    capture();
    nmi_pin <= 1'b1;
    wdt_ovf <= 1'b1;
    tick(1);
    wdt_ovf <= 1'b0;
    wait_for(1'b0, 4);
    chk_entry(WDT_CAUSE, nm_pc);
    tick(2);
    rd(8'h04);
    chk("pin dropped", 32'h0000_0002, d);
    $display("test watchdog done");
    do_reset();
    nmi_pin <= 1'b0;
    wr(8'h00, 32'h0000_0013);
    capture();
    nmi_pin <= 1'b1;
    wait_for(1'b0, 4);
    chk_pin();
    nmi_pin <= 1'b0;
    wait_for(1'b0, 4);
    chk("pin nested", 32'h0000_0000, got);
    rd(8'h04);
    chk("pin pending", 32'h0000_0009, d);
    do_return();
    wait_for(1'b0, 4);
    chk("pin after return", 32'h0000_0001, got);
    chk("pin again cause", b(1'b0) | PIN_CAUSE, b(1'b0) | entry.cause);
    wdt_ovf <= 1'b1;
    tick(1);
    wdt_ovf <= 1'b0;
    wait_for(1'b0, 4);
    chk("wdt held", 32'h0000_0000, got);
    status_wdata <= sw_o & 32'hFFFF_FF7F;
    status_write <= 1'b1;
    tick(1);
    status_write <= 1'b0;
    wait_for(1'b0, 4);
    chk("wdt preempt", 32'h0000_0001, got);
    chk("preempt cause", b(1'b0) | WDT_CAUSE, b(1'b0) | entry.cause);
    $display("test nesting done");
    do_reset();
    for (int i = 0; i < 24; i++) begin
      status_wdata <= 32'h0000_0000;
      status_write <= 1'b1;
      abort_in <= 1'($urandom_range(1, 0));
      tick(2);
      status_write <= 1'b0;
      capture();
      d = (i < 3) ? (32'h1 << (26 - 11 * i + (i == 2) * 10)) : $urandom();
      mreq <= d[MASK_SOURCES-1:0] | 27'h400_0000;
      lo = 26;
      for (int j = 26; j >= 0; j--) if (d[j]) lo = j;
      wait_for(1'b0, 4);
      chk_entry(MASK_CODE_LO + 16'(lo * 16), mk_pc);
      chk("ack index", b(1'b0) | lo, b(1'b0) | ack_idx);
      mreq <= '0;
    end
    wr(8'h00, 32'h0000_0003);
    capture();
    mreq <= '1;
    nmi_pin <= 1'b1;
    wait_for(1'b0, 4);
    chk_pin();
    do_return();
    mreq <= '0;
    capture();
    illegal_in <= 1'b1;
    tick(1);
    illegal_in <= 1'b0;
    wait_for(1'b0, 4);
    chk("illegal cause", b(1'b0) | ILLEGAL_CAUSE, b(1'b0) | entry.cause);
    chk("illegal pc", ctx.current_address + ILLEGAL_STEP, mk_pc);
    $display("test maskable done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
